// ### rtl/lsac_ctrl.sv
// Local loopback path selection and store align control register logic
//
// Overview of operation
// R01 - Local loopback enable bit one enters loopback, zero leaves it.
// R02 - Transmit data to the line is unchanged during local loopback.
// R03 - In loopback the receive path takes transmit data, ignoring line input.
// R04 - Looped data goes through the jitter attenuator, not around it.
// R05 - Control register at AA hex: reset, rx align, tx align, 5-bit select.
// R06 - Rising reset trigger pulses reset to clock recovery and attenuator.
// R07 - Software clears then sets reset trigger again for another reset.
// R08 - Rising rx align trigger requests rx store pointers half frame apart.
// R09 - Rising tx align trigger requests tx store pointers half frame apart.
// R10 - Align does nothing when separation is already half a frame or more.
// R11 - Below half a frame, pointers are moved and data may corrupt.
// R12 - Software raises rx align only with a stable receive system clock.
// R13 - Software raises tx align only with a stable transmit system clock.
// R14 - Software clears then sets an align trigger for each further align.
// R15 - Five-bit select chooses receive channel copied into monitor register.
// R16 - Loopback bit is bit 6 of register at A8 hex.
// R17 - Rising edges found by comparing written and stored value; one pulse.
`timescale 1ns/1ps
module lsac_ctrl (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  input wire logic tx_line_pos_i,
  input wire logic tx_line_neg_i,
  input wire logic line_rx_positive_i,
  input wire logic line_rx_negative_i,
  input wire logic rx_store_sep_ok_i,
  input wire logic tx_store_sep_ok_i,
  output logic tx_line_pos_o,
  output logic tx_line_neg_o,
  output logic jatt_in_pos_o,
  output logic jatt_in_neg_o,
  output logic local_loopback_enable_o,
  output logic line_iface_reset_o,
  output logic rx_store_align_o,
  output logic tx_store_align_o,
  output logic [4:0] rx_monitor_sel_o
);
  // Bus request carried as one word through the decode
  lsac_pkg::lsac_bus_req_t req;

  // Register state and its next values
  logic [7:0] loop_and_tx_monitor_ctrl;
  logic [7:0] next_loop_and_tx_monitor_ctrl;
  logic [7:0] line_store_monitor_ctrl;
  logic [7:0] next_line_store_monitor_ctrl;

  // Address decode results
  logic wr_loop_reg;
  logic wr_store_reg;
  logic rd_loop_reg;
  logic rd_store_reg;

  // Trigger edges as seen by the write, before the separation gate
  logic line_iface_reset_trigger_rise;
  logic rx_align_rise;
  logic tx_align_rise;

  // Pulse stage and output stage next values
  lsac_pkg::lsac_pulse_t pulse;
  lsac_pkg::lsac_pulse_t next_pulse;
  logic next_reset_out;
  logic next_rx_align_out;
  logic next_tx_align_out;
  logic [7:0] next_rdata;
  logic next_tx_pos;
  logic next_tx_neg;
  logic loop_on;
  logic next_ja_pos;
  logic next_ja_neg;
  logic next_loopback;
  logic [4:0] next_sel;

  // True when a bit goes from zero in the stored value to one in the write
  function automatic logic rose(
    input logic old_b,
    input logic new_b
  );
    return !old_b && new_b;
  endfunction

  // True when a strobe is raised toward the given register address
  function automatic logic hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && (addr == target);
  endfunction

  // Two-way selector used for both rails of the attenuator input
  function automatic logic pick(
    input logic sel,
    input logic when_one,
    input logic when_zero
  );
    logic res;
    if (sel) begin
      res = when_one;
    end else begin
      res = when_zero;
    end
    return res;
  endfunction

  assign req = '{wr: bus_wr_i, rd: bus_rd_i, addr: bus_addr_i,
                 wdata: bus_wdata_i};

  // Address decode, shared by the register, edge and read groups
  always_comb begin
    wr_loop_reg = hit(req.wr, req.addr, lsac_pkg::LOOP_TX_MON_CTRL_ADDR);
    wr_store_reg = hit(req.wr, req.addr,
      lsac_pkg::LINE_STORE_MON_CTRL_ADDR);
    rd_loop_reg = hit(req.rd, req.addr, lsac_pkg::LOOP_TX_MON_CTRL_ADDR);
    rd_store_reg = hit(req.rd, req.addr,
      lsac_pkg::LINE_STORE_MON_CTRL_ADDR);
  end

  // Writes land at the edge; unmapped addresses are ignored
  always_comb begin
    next_loop_and_tx_monitor_ctrl = loop_and_tx_monitor_ctrl;
    next_line_store_monitor_ctrl = line_store_monitor_ctrl;
    if (wr_loop_reg) begin
      // All eight bits are kept so that a read returns what was written
      next_loop_and_tx_monitor_ctrl = req.wdata; // see R16
    end
    if (wr_store_reg) begin
      next_line_store_monitor_ctrl = req.wdata; // see R05
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_and_tx_monitor_ctrl <= lsac_pkg::CTRL_RESET;
      line_store_monitor_ctrl <= lsac_pkg::CTRL_RESET;
    end else begin
      loop_and_tx_monitor_ctrl <= next_loop_and_tx_monitor_ctrl;
      line_store_monitor_ctrl <= next_line_store_monitor_ctrl;
    end
  end

  // Edge detect compares the written bit with the stored one
  always_comb begin
    line_iface_reset_trigger_rise = 1'b0;
    rx_align_rise = 1'b0;
    tx_align_rise = 1'b0;
    if (wr_store_reg) begin
      line_iface_reset_trigger_rise = rose(
        line_store_monitor_ctrl[lsac_pkg::LINE_IFACE_RESET_BIT],
        req.wdata[lsac_pkg::LINE_IFACE_RESET_BIT]); // see R17
      // Holding a bit at one gives no new edge; a clear must come first
      rx_align_rise = rose(
        line_store_monitor_ctrl[lsac_pkg::RX_ALIGN_BIT],
        req.wdata[lsac_pkg::RX_ALIGN_BIT]); // see R14 see R17
      tx_align_rise = rose(
        line_store_monitor_ctrl[lsac_pkg::TX_ALIGN_BIT],
        req.wdata[lsac_pkg::TX_ALIGN_BIT]); // see R14 see R17
    end
  end

  // An align with the pointers already far enough apart is dropped here
  always_comb begin
    next_pulse = '0;
    next_pulse.line_iface_reset = line_iface_reset_trigger_rise; // see R06
    next_pulse.rx_store_align = rx_align_rise &&
      !rx_store_sep_ok_i; // see R08 see R10
    next_pulse.tx_store_align = tx_align_rise &&
      !tx_store_sep_ok_i; // see R09 see R10
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulse <= '0;
    end else begin
      pulse <= next_pulse;
    end
  end

  // Unmapped or idle cycles read as zero
  always_comb begin
    next_rdata = '0;
    if (rd_loop_reg) begin
      next_rdata = loop_and_tx_monitor_ctrl;
    end
    if (rd_store_reg) begin
      next_rdata = line_store_monitor_ctrl;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_rdata_o <= '0;
    end else begin
      bus_rdata_o <= next_rdata;
    end
  end

  // Transmit rails pass toward the line untouched in every mode
  always_comb begin
    next_tx_pos = tx_line_pos_i; // see R02
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_line_pos_o <= 1'b0;
    end else begin
      tx_line_pos_o <= next_tx_pos;
    end
  end

  // Negative rail follows the same single-cycle path
  always_comb begin
    next_tx_neg = tx_line_neg_i; // see R02
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_line_neg_o <= 1'b0;
    end else begin
      tx_line_neg_o <= next_tx_neg;
    end
  end

  // The attenuator sits after the mux, so looped data passes through it
  always_comb begin
    loop_on = loop_and_tx_monitor_ctrl[lsac_pkg::LOCAL_LOOPBACK_BIT];
    next_ja_pos = pick(loop_on, tx_line_pos_i,
      line_rx_positive_i); // see R01 see R03 see R04
    next_ja_neg = pick(loop_on, tx_line_neg_i,
      line_rx_negative_i); // see R03 see R04
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      jatt_in_pos_o <= 1'b0;
      jatt_in_neg_o <= 1'b0;
    end else begin
      jatt_in_pos_o <= next_ja_pos;
      jatt_in_neg_o <= next_ja_neg;
    end
  end

  // Level outputs show the register contents from the edge after a write
  always_comb begin
    next_loopback = next_loop_and_tx_monitor_ctrl[
      lsac_pkg::LOCAL_LOOPBACK_BIT]; // see R01
    next_sel = next_line_store_monitor_ctrl[
      lsac_pkg::MON_SEL_MSB:lsac_pkg::MON_SEL_LSB]; // see R15
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      local_loopback_enable_o <= 1'b0;
      rx_monitor_sel_o <= lsac_pkg::MON_SEL_RESET;
    end else begin
      local_loopback_enable_o <= next_loopback;
      rx_monitor_sel_o <= next_sel;
    end
  end

  // Line interface reset stays one cycle wide at its pin
  always_comb begin
    next_reset_out = pulse.line_iface_reset; // see R06
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_iface_reset_o <= 1'b0;
    end else begin
      line_iface_reset_o <= next_reset_out;
    end
  end

  // Receive align reaches the store for exactly one cycle
  always_comb begin
    next_rx_align_out = pulse.rx_store_align; // see R11
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_store_align_o <= 1'b0;
    end else begin
      rx_store_align_o <= next_rx_align_out;
    end
  end

  // Transmit align reaches the store for exactly one cycle
  always_comb begin
    next_tx_align_out = pulse.tx_store_align; // see R11
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_store_align_o <= 1'b0;
    end else begin
      tx_store_align_o <= next_tx_align_out;
    end
  end
endmodule

// ### rtl/lsac_pkg.sv
// Package for the loopback, store align and monitor control block
package lsac_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] LOOP_TX_MON_CTRL_ADDR = 8'hA8;
  localparam logic [7:0] LINE_STORE_MON_CTRL_ADDR = 8'hAA;
  localparam int unsigned LOCAL_LOOPBACK_BIT = 6;
  localparam int unsigned LINE_IFACE_RESET_BIT = 7;
  localparam int unsigned RX_ALIGN_BIT = 6;
  localparam int unsigned TX_ALIGN_BIT = 5;
  localparam int unsigned MON_SEL_MSB = 4;
  localparam int unsigned MON_SEL_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] MON_SEL_RESET = 5'h00;

  // Reads and writes from the parallel control port, already decoded as one cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsac_bus_req_t;

  // One-cycle action pulses toward the line interface and elastic stores
  typedef struct packed {
    logic line_iface_reset;
    logic rx_store_align;
    logic tx_store_align;
  } lsac_pulse_t;
endpackage

// ### verification/lsac_monitor.sv
// Port checker for the loopback and store align control block
`timescale 1ns/1ps
module lsac_monitor (
  input wire logic clk_i, arst_n_i, bus_wr_i, bus_rd_i,
  input wire logic [7:0] bus_addr_i, bus_wdata_i, bus_rdata_o,
  input wire logic tx_line_pos_i, line_rx_positive_i, tx_line_pos_o,
  input wire logic jatt_in_pos_o, local_loopback_enable_o,
  input wire logic rx_store_sep_ok_i, tx_store_sep_ok_i,
  input wire logic line_iface_reset_o, rx_store_align_o, tx_store_align_o,
  input wire logic [4:0] rx_monitor_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0] sh;
  wire wa = bus_wr_i && bus_addr_i == 8'hAA;
  // Old stored value decides whether a written one is a rising edge
  wire [2:0] up = bus_wdata_i[7:5] & ~sh[7:5] & {3{wa}};
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i) sh <= 8'h00;
    else if (wa) sh <= bus_wdata_i;
  chk_loop_level: assert property (bus_wr_i && bus_addr_i == 8'hA8
    |=> local_loopback_enable_o == $past(bus_wdata_i[6])) else $error("loop");
  chk_sel_level: assert property (wa
    |=> rx_monitor_sel_o == $past(bus_wdata_i[4:0])) else $error("sel");
  chk_tx_pass: assert property (arst_n_i
    |=> tx_line_pos_o == $past(tx_line_pos_i)) else $error("tx path");
  chk_jatt_source: assert property (arst_n_i |=> jatt_in_pos_o ==
    ($past(local_loopback_enable_o) ? $past(tx_line_pos_i)
    : $past(line_rx_positive_i))) else $error("jatt");
  chk_reset_rise: assert property (up[2]
    |=> ##1 line_iface_reset_o) else $error("line_iface_reset_trigger");
  chk_rx_align: assert property (up[1] && !rx_store_sep_ok_i
    |=> ##1 rx_store_align_o) else $error("rx align");
  chk_rx_skip: assert property (up[1] && rx_store_sep_ok_i
    |=> ##1 !rx_store_align_o) else $error("rx skip");
  chk_tx_align: assert property (up[0] && !tx_store_sep_ok_i
    |=> ##1 tx_store_align_o) else $error("tx align");
  chk_pulse_single: assert property (line_iface_reset_o
    |=> !line_iface_reset_o) else $error("pulse");
  chk_read_back: assert property (bus_rd_i && bus_addr_i == 8'hAA
    |=> bus_rdata_o == $past(sh)) else $error("read");
  cover property (up[1] && !rx_store_sep_ok_i);
  cover property (up[2]);
  cover property (bus_wr_i && bus_addr_i == 8'hA8 && bus_wdata_i[6]);
endmodule

// ### verification/tb_top.sv
// Random self-checking bench for the loopback and store align block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0;
  logic arst_n_i = 0;
  lsac_pkg::lsac_bus_req_t q = '0;
  logic [3:0] d = '0;
  logic [1:0] s = '0;
  logic [7:0] r, m8, ma, er;
  logic [12:0] o;
  logic [2:0] pd, ep;
  logic [3:0] ed;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  lsac_ctrl u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_wr_i(q.wr),
    .bus_rd_i(q.rd), .bus_addr_i(q.addr), .bus_wdata_i(q.wdata),
    .bus_rdata_o(r), .tx_line_pos_i(d[0]), .tx_line_neg_i(d[1]),
    .line_rx_positive_i(d[2]), .line_rx_negative_i(d[3]),
    .rx_store_sep_ok_i(s[1]), .tx_store_sep_ok_i(s[0]),
    .tx_line_pos_o(o[0]), .tx_line_neg_o(o[1]), .jatt_in_pos_o(o[2]),
    .jatt_in_neg_o(o[3]), .local_loopback_enable_o(o[4]),
    .line_iface_reset_o(o[5]), .rx_store_align_o(o[6]),
    .tx_store_align_o(o[7]), .rx_monitor_sel_o(o[12:8]));
  // Reference model sees inputs as sampled at the edge
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {m8, ma, er, pd, ep, ed} = '0;
    end else begin
      ep = pd;
      pd = q.wdata[7:5] & ~ma[7:5] & {3{q.wr && q.addr == 8'hAA}}
        & {1'b1, ~s};
      er = !q.rd ? 8'h00 : q.addr == 8'hA8 ? m8
        : q.addr == 8'hAA ? ma : 8'h00;
      ed = {m8[6] ? d[1:0] : d[3:2], d[1:0]};
      if (q.wr && q.addr == 8'hA8) m8 = q.wdata;
      if (q.wr && q.addr == 8'hAA) ma = q.wdata;
    end
  end
  task automatic check(input string n, input logic [17:0] e,
    input logic [17:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk_i) begin
    check("levels", {er, ma[4:0], m8[6], ed},
      {r, o[12:8], o[4:0]});
    check("pulses", {15'h0000, ep[0], ep[1], ep[2]},
      {15'h0000, o[7:5]});
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    void'($urandom(71));
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk_i);
      // A short second reset checks recovery in mid-run
      arst_n_i <= i < 2000 || i > 2003;
      q <= {1'($urandom), 1'($urandom), i % 3 == 0 ? 8'($urandom)
        : ($urandom & 1) ? 8'hA8 : 8'hAA, 8'($urandom)};
      d <= 4'($urandom);
      s <= 2'($urandom);
    end
    summarize();
  end
endmodule
bind lsac_ctrl lsac_monitor u_mon (.*);
